// file: rtl/relative_jump_decision_unit.sv
// Decode, target and decision for the three relative jump instructions
`timescale 1ns/100ps
`default_nettype none
module relative_jump_decision_unit (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_nrst,
    input  wire jump_decide_pkg::jump_req_t i_req,
    output var  jump_decide_pkg::jump_res_t o_res
);
    import jump_decide_pkg::*;

    logic [4:0]  opc;
    logic        dly;
    logic [4:0]  sel;
    logic [31:0] src;
    logic [31:0] short_displacement;
    logic [31:0] long_displacement;
    logic        sign_bit;
    logic        zero_bit;
    logic [1:0]  cond_idx;
    logic [3:0]  cond_bits;
    logic [31:0] bit_hit;
    logic        bit_taken;
    logic        is_bit_one;
    logic        is_zero_cmp;
    logic        is_uncond;
    jump_res_t   res_d;
    jump_res_t   res_q;

    // One comparator per source bit; only the selected bit can hit
    for (genvar n = 0; n <= OPC_HI; n++) begin : g_bit_pick
        assign bit_hit[n] = (sel == 5'(n)) && src[n];
    end
    assign bit_taken = |bit_hit;
    assign is_bit_one = i_req.valid && (opc == OPC_BIT_ONE);
    assign is_zero_cmp = i_req.valid && (opc == OPC_ZERO_CMP);
    assign is_uncond = i_req.valid && (opc == OPC_UNCOND);

    always_comb begin
        opc = i_req.word[OPC_HI:OPC_LO];
        dly = i_req.word[DLY_BIT];
        sel = i_req.word[SEL_HI:SEL_LO];
        src = i_req.first_source_register;
        short_displacement = {{(OPC_HI-SDISP_HI-SHIFT){i_req.word[SDISP_HI]}},
                              i_req.word[SDISP_HI:0], {SHIFT{1'b0}}};
        long_displacement = {{(OPC_HI-LDISP_HI-SHIFT){i_req.word[LDISP_HI]}},
                             i_req.word[LDISP_HI:0], {SHIFT{1'b0}}};
        sign_bit = src[OPC_HI];
        zero_bit = ~|src[OPC_HI-1:0];
        cond_idx = {sign_bit, zero_bit};
        // Index 3 sign+zero .. index 0 neither; mask bit 25 not used
        cond_bits = sel[3:0];
        res_d = '0;
        res_d.valid = i_req.valid;
        res_d.fetch_pointer = i_req.executing_pointer + WORD_STEP;
        if (i_req.valid) begin
            case (opc)
                OPC_BIT_ONE: begin
                    res_d.is_jump = 1'b1;
                    res_d.taken = bit_taken;
                end
                OPC_ZERO_CMP: begin
                    res_d.is_jump = 1'b1;
                    res_d.taken = cond_bits[cond_idx];
                end
                OPC_UNCOND: begin
                    res_d.is_jump = 1'b1;
                    res_d.taken = 1'b1;
                end
                default: res_d.is_jump = 1'b0;
            endcase
        end
        if (res_d.taken) begin
            if (opc == OPC_UNCOND) begin
                res_d.fetch_pointer = i_req.executing_pointer + long_displacement;
            end else begin
                res_d.fetch_pointer = i_req.executing_pointer + short_displacement;
            end
            res_d.delay_slot = dly;
            res_d.squash_next = ~dly;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    assign o_res = res_q;

    chk_uncond_always_taken: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && i_req.word[OPC_HI:OPC_LO] == OPC_UNCOND |=> o_res.taken && o_res.valid)
        else $error("unconditional jump not taken");
    chk_delay_squash: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_res.taken |-> (o_res.squash_next != o_res.delay_slot))
        else $error("delay and squash disagree");
    chk_not_taken_seq: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && !res_d.taken |=> o_res.fetch_pointer == $past(i_req.executing_pointer) + WORD_STEP
        && !o_res.squash_next)
        else $error("untaken jump not sequential");
    chk_bit_one_pick: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && i_req.word[OPC_HI:OPC_LO] == OPC_BIT_ONE
        |=> o_res.taken == $past(i_req.first_source_register[i_req.word[SEL_HI:SEL_LO]]))
        else $error("bit test decision wrong");
    chk_zero_cond: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && i_req.word[OPC_HI:OPC_LO] == OPC_ZERO_CMP
        && i_req.word[SEL_HI:SEL_LO] == IS_ZERO_COND |=> o_res.taken == ($past(src) == 32'h0000_0000))
        else $error("is-zero condition wrong");
    chk_neg_cond: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && i_req.word[OPC_HI:OPC_LO] == OPC_ZERO_CMP
        && i_req.word[SEL_HI:SEL_LO] == NEGATIVE_COND |=> o_res.taken == $past(src[OPC_HI]))
        else $error("negative condition wrong");
    chk_mask_top_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp |=> o_res.taken == $past(
            (src[OPC_HI] && ~|src[OPC_HI-1:0] && i_req.word[SEL_HI-1])
            || (src[OPC_HI] && |src[OPC_HI-1:0] && i_req.word[SEL_HI-2])
            || (!src[OPC_HI] && ~|src[OPC_HI-1:0] && i_req.word[SEL_LO+1])
            || (!src[OPC_HI] && |src[OPC_HI-1:0] && i_req.word[SEL_LO])))
        else $error("mask bit 25 affects decision");
    chk_short_target: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && opc == OPC_BIT_ONE && res_d.taken |=> o_res.fetch_pointer
        == $past(i_req.executing_pointer) + {{14{$past(i_req.word[15])}}, $past(i_req.word[15:0]), 2'b00})
        else $error("short target wrong");

    chk_bit_one_clear: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_bit_one && !i_req.first_source_register[sel]
        |=> !o_res.taken && !o_res.squash_next && !o_res.delay_slot)
        else $error("bit test taken on a clear bit");

    chk_bit_one_set: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_bit_one && i_req.first_source_register[sel]
        |=> o_res.taken)
        else $error("bit test not taken on a set bit");

    chk_bit_one_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_bit_one && sel == 5'h00
        |=> o_res.taken == $past(i_req.first_source_register[0]))
        else $error("bit test of lowest bit wrong");

    chk_bit_one_high: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_bit_one && sel == 5'h1F
        |=> o_res.taken == $past(i_req.first_source_register[OPC_HI]))
        else $error("bit test of highest bit wrong");

    chk_bit_one_decode: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_bit_one
        |=> o_res.is_jump && o_res.valid)
        else $error("bit test opcode not decoded");

    chk_bit_one_slot: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_bit_one && i_req.first_source_register[sel]
        |=> o_res.delay_slot == $past(i_req.word[DLY_BIT]))
        else $error("bit test delay flag wrong");

    chk_bit_one_squash: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_bit_one && i_req.first_source_register[sel] && !i_req.word[DLY_BIT]
        |=> o_res.squash_next)
        else $error("bit test did not suppress next");

    chk_bit_one_miss_step: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_bit_one && !i_req.first_source_register[sel]
        |=> o_res.fetch_pointer == $past(i_req.executing_pointer) + WORD_STEP)
        else $error("bit test miss not sequential");

    chk_cond_target: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && res_d.taken |=> o_res.fetch_pointer == $past(i_req.executing_pointer)
        + {{14{$past(i_req.word[15])}}, $past(i_req.word[15:0]), 2'b00})
        else $error("condition jump target wrong");

    chk_target_align: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && res_d.taken
        |=> o_res.fetch_pointer[1:0] == $past(i_req.executing_pointer[1:0]))
        else $error("target not word aligned to pointer");

    chk_long_target: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_uncond |=> o_res.fetch_pointer == $past(i_req.executing_pointer)
        + {{4{$past(i_req.word[25])}}, $past(i_req.word[25:0]), 2'b00})
        else $error("long target wrong");

    chk_slot_keeps_next: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && res_d.taken && i_req.word[DLY_BIT]
        |=> o_res.delay_slot && !o_res.squash_next)
        else $error("delayed jump suppressed next");

    chk_plain_squashes: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && res_d.taken && !i_req.word[DLY_BIT]
        |=> o_res.squash_next && !o_res.delay_slot)
        else $error("plain jump kept next");

    chk_squash_taken: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_res.squash_next
        |-> o_res.taken && o_res.is_jump)
        else $error("suppress without taken jump");

    chk_slot_taken: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_res.delay_slot
        |-> o_res.taken && o_res.is_jump)
        else $error("delay slot without taken jump");

    chk_uncond_slot: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_uncond |=> o_res.delay_slot == $past(i_req.word[DLY_BIT])
        && o_res.squash_next == !$past(i_req.word[DLY_BIT]))
        else $error("unconditional delay flag wrong");

    chk_max_neg_pick: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && src[OPC_HI] && ~|src[OPC_HI-1:0]
        |=> o_res.taken == $past(i_req.word[SEL_HI-1]))
        else $error("sign and zero pick wrong");

    chk_neg_pick: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && src[OPC_HI] && |src[OPC_HI-1:0]
        |=> o_res.taken == $past(i_req.word[SEL_HI-2]))
        else $error("sign only pick wrong");

    chk_zero_pick: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && src == 32'h0000_0000
        |=> o_res.taken == $past(i_req.word[SEL_LO+1]))
        else $error("zero only pick wrong");

    chk_pos_pick: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && !src[OPC_HI] && |src[OPC_HI-1:0]
        |=> o_res.taken == $past(i_req.word[SEL_LO]))
        else $error("neither pick wrong");

    chk_cond_decode: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp
        |=> o_res.is_jump && o_res.valid)
        else $error("condition opcode not decoded");

    chk_cond_empty_mask: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && i_req.word[SEL_HI-1:SEL_LO] == 4'h0
        |=> !o_res.taken)
        else $error("empty mask took jump");

    chk_cond_full_mask: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && i_req.word[SEL_HI-1:SEL_LO] == 4'hF
        |=> o_res.taken)
        else $error("full mask missed jump");

    chk_top_bit_alone: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && i_req.word[SEL_HI:SEL_LO] == 5'h10
        |=> !o_res.taken)
        else $error("mask bit 25 alone took jump");

    chk_nonzero_cond: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && i_req.word[SEL_HI:SEL_LO] == NONZERO_COND
        |=> o_res.taken == ($past(src) != 32'h0000_0000))
        else $error("nonzero condition wrong");

    chk_positive_cond: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && i_req.word[SEL_HI:SEL_LO] == POSITIVE_COND
        |=> o_res.taken == (!$past(src[OPC_HI]) && $past(src) != 32'h0000_0000))
        else $error("positive condition wrong");

    chk_nonneg_cond: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && i_req.word[SEL_HI:SEL_LO] == NONNEGATIVE_COND
        |=> o_res.taken == !$past(src[OPC_HI]))
        else $error("nonnegative condition wrong");

    chk_nonpos_cond: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && i_req.word[SEL_HI:SEL_LO] == NONPOSITIVE_COND
        |=> o_res.taken == ($past(src[OPC_HI]) || $past(src) == 32'h0000_0000))
        else $error("nonpositive condition wrong");

    chk_cond_slot: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && res_d.taken
        |=> o_res.delay_slot == $past(i_req.word[DLY_BIT]))
        else $error("condition delay flag wrong");

    chk_cond_miss_step: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_zero_cmp && !res_d.taken
        |=> o_res.fetch_pointer == $past(i_req.executing_pointer) + WORD_STEP && !o_res.delay_slot)
        else $error("condition miss not sequential");

    chk_uncond_decode: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        is_uncond
        |=> o_res.is_jump && o_res.valid)
        else $error("unconditional opcode not decoded");

    chk_other_opcode: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && !is_bit_one && !is_zero_cmp && !is_uncond
        |=> !o_res.is_jump && !o_res.taken && o_res.valid)
        else $error("other opcode decoded as jump");

    chk_other_step: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_req.valid && !is_bit_one && !is_zero_cmp && !is_uncond
        |=> o_res.fetch_pointer == $past(i_req.executing_pointer) + WORD_STEP)
        else $error("other opcode not sequential");

    chk_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !i_req.valid
        |=> !o_res.valid && !o_res.is_jump && !o_res.taken)
        else $error("idle cycle produced a jump");

    chk_taken_valid: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_res.taken
        |-> o_res.valid && o_res.is_jump)
        else $error("taken without valid jump");
endmodule
`default_nettype wire

// file: rtl/jump_decide_pkg.sv
// Constants and types for the relative jump decision unit
// Function
// - Bit-set jump picks one source bit by bit-select; taken only when it is one.
// - Bit-set jump fields: opcode 31:27, delay 26, bit-select 25:21, source 20:16, disp 15:0.
// - Short displacement is sign-extended, shifted left two, added to instruction address.
// - Delay flag 0 suppresses next instruction on taken jump; 1 executes it first.
// - Sign bit is source MSB; zero bit is NOR of the 31 low bits.
// - Sign and zero bits index the condition mask; jump taken when selected bit set.
// - Mask bit 24 sign+zero, 23 sign only, 22 zero only, 21 neither.
// - Mask bit 25 is ignored by the jump selection logic.
// - Named conditions map to fixed mask values, bit 25 down to bit 21.
// - Zero-compare jump fields: opcode 31:27, delay 26, mask 25:21, source 20:16, disp 15:0.
// - Unconditional jump always taken; target is address plus shifted long displacement.
// - Unconditional jump fields: opcode 31:27, delay 26, long displacement 25:0.
package jump_decide_pkg;
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 27;
    localparam int DLY_BIT = 26;
    localparam int SEL_HI = 25;
    localparam int SEL_LO = 21;
    localparam int SRC_HI = 20;
    localparam int SRC_LO = 16;
    localparam int SDISP_HI = 15;
    localparam int LDISP_HI = 25;
    localparam int SHIFT = 2;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [4:0] OPC_BIT_ONE = 5'h1B;
    localparam logic [4:0] OPC_ZERO_CMP = 5'h1D;
    localparam logic [4:0] OPC_UNCOND = 5'h18;
    localparam logic [4:0] IS_ZERO_COND = 5'h02;
    localparam logic [4:0] NONZERO_COND = 5'h0D;
    localparam logic [4:0] POSITIVE_COND = 5'h01;
    localparam logic [4:0] NEGATIVE_COND = 5'h0C;
    localparam logic [4:0] NONNEGATIVE_COND = 5'h03;
    localparam logic [4:0] NONPOSITIVE_COND = 5'h0E;

    typedef struct packed {
        logic        valid;
        logic [31:0] word;
        logic [31:0] executing_pointer;
        logic [31:0] first_source_register;
    } jump_req_t;

    typedef struct packed {
        logic        valid;
        logic        is_jump;
        logic        taken;
        logic        delay_slot;
        logic        squash_next;
        logic [31:0] fetch_pointer;
    } jump_res_t;
endpackage

// file: bench/fetch_seq_model.sv
// Fetch sequencer model that follows each valid result
`timescale 1ns/100ps
`default_nettype none
module fetch_seq_model (
    input  wire logic                       i_sys_clk,
    input  wire jump_decide_pkg::jump_res_t i_res,
    output var  logic [31:0]                o_ptr
);
    import jump_decide_pkg::*;
    initial o_ptr = 32'h0000_1000;
    always @(posedge i_sys_clk) begin
        if (i_res.valid) o_ptr <= i_res.fetch_pointer;
    end
endmodule
`default_nettype wire

// file: bench/relative_jump_decision_unit_tb.sv
// Self-checking bench for the relative jump decision unit
`timescale 1ns/100ps
`default_nettype none
module relative_jump_decision_unit_tb;
    import jump_decide_pkg::*;
    logic        i_sys_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        armed = 1'b0;
    jump_req_t   i_req = '0;
    jump_res_t   o_res;
    jump_res_t   exp_q[$];
    logic [31:0] ptr;
    logic [4:0]  op;
    int          bad_count = 0;
    int          n_compared = 0;
    int          seed = 56;
    logic [4:0]  ops[4] = '{OPC_BIT_ONE, OPC_ZERO_CMP, OPC_UNCOND, 5'h00};
    logic [4:0]  conds[6] = '{IS_ZERO_COND, NONZERO_COND, POSITIVE_COND,
                              NEGATIVE_COND, NONNEGATIVE_COND, NONPOSITIVE_COND};
    logic [31:0] regs[4] = '{32'h0, 32'h8000_0000, 32'h1, 32'hFFFF_FFFF};
    always #12.5 i_sys_clk = ~i_sys_clk;
    relative_jump_decision_unit u_relative_jump_decision_unit (.i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst), .i_req(i_req), .o_res(o_res));
    fetch_seq_model u_fetch_seq_model (.i_sys_clk(i_sys_clk), .i_res(o_res), .o_ptr(ptr));
    function automatic jump_res_t model(jump_req_t r);
        jump_res_t   e;
        logic [31:0] d;
        logic [31:0] s;
        s = r.first_source_register;
        d = {{14{r.word[15]}}, r.word[15:0], 2'b00};
        e = '0;
        e.valid = r.valid;
        e.is_jump = r.valid;
        case (r.word[31:27])
            OPC_BIT_ONE: e.taken = s[r.word[25:21]];
            OPC_ZERO_CMP: e.taken = r.word[21 + {s[31], ~|s[30:0]}];
            OPC_UNCOND: begin
                e.taken = 1'b1;
                d = {{4{r.word[25]}}, r.word[25:0], 2'b00};
            end
            default: e.is_jump = 1'b0;
        endcase
        e.taken = e.taken & r.valid;
        e.delay_slot = e.taken & r.word[26];
        e.squash_next = e.taken & ~r.word[26];
        e.fetch_pointer = r.executing_pointer + (e.taken ? d : WORD_STEP);
        return e;
    endfunction
    task automatic drive(input logic [4:0] o, input logic [4:0] sel, input logic [31:0] s);
        logic [4:0] prev;
        logic       slot;
        slot = 1'b1;
        while (slot) begin
            @(posedge i_sys_clk);
            if (armed) exp_q.push_back(model(i_req));
            armed = 1'b1;
            prev = i_req.word[31:27];
            // Filler word when the previous request was a delayed jump
            slot = i_req.valid && i_req.word[26]
                   && (prev == OPC_BIT_ONE || prev == OPC_ZERO_CMP || prev == OPC_UNCOND);
            i_req <= '{($random(seed) % 8) != 0, {(slot ? 5'h00 : o), 1'($random(seed)), sel,
                       21'($random(seed))}, ptr, s};
        end
    endtask
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(negedge i_sys_clk) begin
        if (exp_q.size() > 0) begin
            n_compared++;
            if (o_res !== exp_q[0]) begin
                bad_count++;
                $display("unexpected at %0t: got %h want %h", $time, o_res, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end
    initial begin
        #(25 * 2000);
        bad_count++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        foreach (conds[c]) foreach (regs[k])
            drive(OPC_ZERO_CMP, {1'($random(seed)), conds[c][3:0]}, regs[k]);
        $display("condition test done");
        foreach (regs[k]) begin
            drive(OPC_BIT_ONE, 5'h00, regs[k]);
            drive(OPC_BIT_ONE, 5'h1F, regs[k]);
            drive(OPC_ZERO_CMP, 5'h10, regs[k]);
        end
        $display("edge select test done");
        repeat (400) begin
            op = ops[2'($random(seed))];
            drive(op, 5'($random(seed)), $random(seed));
        end
        $display("random mix test done");
        repeat (3) @(posedge i_sys_clk);
        conclude();
    end
endmodule
`default_nettype wire
